// >>> sfr_pkg.sv
// Overview of operation
// [RULE_01] overrun and bit-error events each set own flag and raise interrupt
// [RULE_02] flag set in same cycle as a clearing flag read survives
// [RULE_03] upper-half buffer read does not drop a flag set that cycle
// [RULE_04] buffer read clears rx full, unless new data arrives that cycle
// [RULE_05] writing one to overrun bit clears it, unless overrun sets that cycle
// [RULE_06] each source maps to level zero or one with own vector register
// [RULE_07] debug-mode reads of vector and flag registers clear nothing
// [RULE_08] polarity change at new buffer start is not taken as a clock edge
// [RULE_09] byte write of format selector alone picks format, starts nothing
// [RULE_10] word completing while rx full still set raises overrun
package sfr_pkg;
	localparam logic [7:0] off_gcr = 8'h00;
	localparam logic [7:0] off_int_en = 8'h04;
	localparam logic [7:0] off_level = 8'h08;
	localparam logic [7:0] off_flag = 8'h0C;
	localparam logic [7:0] off_fmt0 = 8'h10;
	localparam logic [7:0] off_fmt1 = 8'h14;
	localparam logic [7:0] off_tx = 8'h18;
	localparam logic [7:0] off_rxbuf = 8'h1C;
	localparam logic [7:0] off_vec0 = 8'h20;
	localparam logic [7:0] off_vec1 = 8'h24;
	localparam int bit_biterr = 0;
	localparam int bit_overrun = 1;
	localparam int bit_rxfull = 2;
	localparam int fmt_sel_bit = 24;
	localparam int fmt_pol_bit = 8;
	localparam logic [7:0] fmt_div_reset = 8'h04;
	localparam logic [3:0] fmt_len_reset = 4'h8;
	localparam logic [2:0] flag_reset = 3'h0;
	localparam int clk_mhz = 40;
	localparam int pin_ns = 100;
	localparam int pin_cycles = (pin_ns * clk_mhz + 999) / 1000;
	typedef struct packed {
		logic sel;
		logic [15:0] data;
	} sfr_tx_type;
	typedef enum logic [1:0] {
		vec_none,
		vec_biterr,
		vec_overrun,
		vec_rxfull
	} sfr_vec_type;
endpackage

// >>> sfr_core.sv
`timescale 1ns/1ps
module sfr_core import sfr_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic debug_mode,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic serial_clock_pin,
	output logic mosi,
	input wire logic miso,
	output logic irq_level0,
	output logic irq_level1,
	output logic irq
);
	typedef enum {st_idle, st_lead, st_run} sfr_state_type;
	sfr_state_type state;
	logic [2:0] serial_flag_reg;
	logic [2:0] int_en;
	logic [2:0] level;
	logic [8:0] data_format_regs [2];
	logic format_selector;
	logic [15:0] rx_buffer_reg;
	logic [15:0] tx_shift;
	logic [15:0] rx_shift;
	logic [4:0] bit_cnt;
	logic [7:0] div_cnt;
	logic clk_int;
	logic enable;
	logic miso_s1, miso_s2;
	logic acc, wr, rd, dbg_rd;
	logic tx_start, sel_only;
	logic word_done, bit_err, rx_set, ovr_set;
	logic flag_read, buf_read, buf_hi_read;
	logic [2:0] pend;
	sfr_vec_type next_vec0, next_vec1;

	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign dbg_rd = rd & debug_mode;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign sel_only = pstrb == 4'b1000; // RULE_09
	assign tx_start = wr && paddr == off_tx && pstrb[1:0] != 2'b00 &&
		state == st_idle; // RULE_09
	assign flag_read = rd && !debug_mode &&
		(paddr == off_flag || paddr == off_vec0 || paddr == off_vec1);
	assign buf_read = rd && !debug_mode && paddr == off_rxbuf; // RULE_07
	assign buf_hi_read = buf_read;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			miso_s1 <= 1'b0;
			miso_s2 <= 1'b0;
		end else begin
			miso_s1 <= miso;
			miso_s2 <= miso_s1;
		end
	end

	// config registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable <= 1'b0;
			int_en <= flag_reset;
			level <= flag_reset;
			data_format_regs[0] <= {1'b0, fmt_div_reset};
			data_format_regs[1] <= {1'b0, fmt_div_reset};
			format_selector <= 1'b0;
		end else if (wr) begin
			unique case (paddr)
				off_gcr: enable <= pwdata[0];
				off_int_en: int_en <= pwdata[2:0];
				off_level: level <= pwdata[2:0]; // RULE_06
				off_fmt0: data_format_regs[0] <= pwdata[8:0];
				off_fmt1: data_format_regs[1] <= pwdata[8:0];
				off_tx: if (pstrb[3]) format_selector <= pwdata[fmt_sel_bit]; // RULE_09
				default: ;
			endcase
		end
	end

	// shift engine; divider from format, idle level follows polarity
	logic pol;
	logic [7:0] div;
	assign pol = data_format_regs[format_selector][fmt_pol_bit];
	assign div = data_format_regs[format_selector][7:0];
	logic tick;
	assign tick = div_cnt == 8'h00;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= st_idle;
			clk_int <= 1'b0;
			div_cnt <= 8'h00;
			bit_cnt <= 5'h00;
			tx_shift <= 16'h0000;
			rx_shift <= 16'h0000;
		end else begin
			div_cnt <= tick ? div : div_cnt - 8'h01;
			unique case (state)
				st_idle: begin
					// idle level moves to new polarity here, with no shift:
					// the edge is not a sample edge
					clk_int <= 1'b0; // RULE_08
					if (tx_start && enable && !sel_only) begin
						tx_shift <= pwdata[15:0];
						bit_cnt <= 5'h10;
						div_cnt <= div;
						state <= st_lead;
					end
				end
				st_lead: if (tick) state <= st_run; // RULE_08
				st_run: if (tick) begin
					clk_int <= ~clk_int;
					if (!clk_int) begin
						rx_shift <= {rx_shift[14:0], miso_s2};
						bit_cnt <= bit_cnt - 5'h01;
					end else begin
						tx_shift <= {tx_shift[14:0], 1'b0};
						if (bit_cnt == 5'h00) state <= st_idle;
					end
				end
			endcase
		end
	end

	logic done_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) done_q <= 1'b0;
		else done_q <= state == st_run && tick && clk_int && bit_cnt == 5'h00;
	end
	assign word_done = done_q;
	// a mismatch anywhere in the word is reported once, at word end
	assign bit_err = word_done & err_seen; // RULE_01

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) rx_buffer_reg <= 16'h0000;
		else if (word_done) rx_buffer_reg <= rx_shift;
	end

	logic mis_bit;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) mis_bit <= 1'b0;
		else mis_bit <= state == st_run && tick && !clk_int &&
			miso_s2 != tx_shift[15];
	end
	logic err_seen;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) err_seen <= 1'b0;
		else if (tx_start) err_seen <= 1'b0;
		else if (mis_bit) err_seen <= 1'b1;
	end

	assign rx_set = word_done;
	assign ovr_set = word_done && serial_flag_reg[bit_rxfull] && !buf_read; // RULE_10

	// flags: set always wins over any clear
	logic [2:0] set_v, clr_v;
	always_comb begin
		set_v = {rx_set, ovr_set, bit_err}; // RULE_01
		clr_v = 3'b000;
		if (buf_read) clr_v[bit_rxfull] = 1'b1; // RULE_04
		if (flag_read) clr_v[1:0] = 2'b11; // RULE_02
		if (buf_hi_read) clr_v[1:0] = 2'b11; // RULE_03
		if (wr && paddr == off_flag) clr_v = clr_v | pwdata[2:0]; // RULE_05
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) serial_flag_reg <= flag_reset;
		else serial_flag_reg <= set_v | (serial_flag_reg & ~clr_v); // RULE_02
	end

	assign pend = serial_flag_reg & int_en;
	always_comb begin
		next_vec0 = vec_none;
		next_vec1 = vec_none;
		for (int i = 2; i >= 0; i--) begin
			if (pend[i] && !level[i]) next_vec0 = sfr_vec_type'(2'(i + 1));
			if (pend[i] && level[i]) next_vec1 = sfr_vec_type'(2'(i + 1));
		end
	end
	assign irq_level0 = next_vec0 != vec_none; // RULE_06
	assign irq_level1 = next_vec1 != vec_none; // RULE_06
	assign irq = irq_level0 | irq_level1;
	assign serial_clock_pin = clk_int ^ pol;
	assign mosi = tx_shift[15];

	always_comb begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			off_gcr: prdata = {31'h0, enable};
			off_int_en: prdata = {29'h0, int_en};
			off_level: prdata = {29'h0, level};
			off_flag: prdata = {29'h0, serial_flag_reg};
			off_fmt0: prdata = {23'h0, data_format_regs[0]};
			off_fmt1: prdata = {23'h0, data_format_regs[1]};
			off_tx: prdata = {7'h0, format_selector, 8'h0, tx_shift};
			off_rxbuf: prdata = {13'h0, serial_flag_reg, rx_buffer_reg};
			off_vec0: prdata = {30'h0, next_vec0};
			off_vec1: prdata = {30'h0, next_vec1};
			default: prdata = 32'h0000_0000;
		endcase
	end

	flag_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		rx_set |=> serial_flag_reg[bit_rxfull]) // RULE_04
		else $error("rx full lost on set");
	ovr_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(word_done && serial_flag_reg[bit_rxfull] && !buf_read)
		|=> serial_flag_reg[bit_overrun]) // RULE_10
		else $error("overrun not set");
	dbg_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		(dbg_rd && !word_done && !wr) |=> $stable(serial_flag_reg)) // RULE_07
		else $error("debug read changed flags");
	ovr_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == off_flag && pwdata[bit_overrun] && !ovr_set)
		|=> !serial_flag_reg[bit_overrun]) // RULE_05
		else $error("overrun write clear failed");
	read_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(buf_read && !rx_set) |=> !serial_flag_reg[bit_rxfull]) // RULE_04
		else $error("rx full not cleared");
	sel_only_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == off_tx && sel_only && state == st_idle)
		|=> state == st_idle) // RULE_09
		else $error("selector write started transfer");
	lead_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state == st_idle ##1 state == st_lead) |-> !clk_int) // RULE_08
		else $error("shift clock active at start");
	level_a: assert property (@(posedge pclk) disable iff (!presetn)
		(pend[bit_overrun] && level[bit_overrun]) |-> irq_level1) // RULE_06
		else $error("level one missing");
	biterr_a: assert property (@(posedge pclk) disable iff (!presetn)
		(word_done && err_seen) |=> serial_flag_reg[bit_biterr]) // RULE_01
		else $error("bit error lost");
	c_word: cover property (@(posedge pclk) word_done);
	c_ovr: cover property (@(posedge pclk) ovr_set);
	c_race: cover property (@(posedge pclk) rx_set && buf_read);
	c_dbg: cover property (@(posedge pclk) dbg_rd);
endmodule // sfr_core

// >>> sfr_slave.sv
`timescale 1ns/1ps
module sfr_slave (
	input wire logic mosi,
	input wire logic flip,
	output logic miso
);
	// echo keeps the received word equal to the sent one; flip corrupts it
	assign miso = mosi ^ flip;
endmodule // sfr_slave

// >>> tb.sv
`timescale 1ns/1ps
module tb import sfr_pkg::*; ;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic debug_mode = 0, flip = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata, m;
	logic pready, pslverr, sck, mosi, miso, irq0, irq1, irq;
	logic [31:0] exp_q[$], mask_q[$];
	logic [31:0] lfsr = 32'hd8d7_8a32, w;
	int mismatches = 0, total_checks = 0, cycles = 0;
	always #12.5 pclk = ~pclk;
	sfr_core u_sfr_core (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .debug_mode(debug_mode), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .serial_clock_pin(sck),
		.mosi(mosi), .miso(miso), .irq_level0(irq0), .irq_level1(irq1),
		.irq(irq));
	sfr_slave u_sfr_slave (.mosi(mosi), .flip(flip), .miso(miso));
	function automatic logic [31:0] next_lfsr(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (e !== g) begin
			mismatches++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d,
		logic [3:0] s, logic [31:0] e, logic [31:0] mk);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		if (!wr) begin
			exp_q.push_back(e);
			mask_q.push_back(mk);
		end
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (!pready) @(posedge pclk);
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb(1, a, d, 4'hf, 32'h0000_0000, 32'h0000_0000);
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] mk);
		apb(0, a, 32'h0000_0000, 4'hf, e, mk);
	endtask
	// a word lasts 32 half periods of div+1 cycles plus the lead
	task automatic send(logic sel);
		lfsr = next_lfsr(lfsr);
		w = lfsr;
		wr(off_tx, {7'h00, sel, 8'h00, w[15:0]});
		repeat (250) @(posedge pclk);
	endtask
	// read data is taken at the edge that completes the access
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			m = mask_q.pop_front();
			chk("prdata", exp_q.pop_front() & m, prdata & m);
		end
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			stop_test();
		end
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		rd(off_flag, 32'h0000_0000, 32'h0000_0007);
		wr(off_gcr, 32'h0000_0001);
		wr(off_int_en, 32'h0000_0007);
		wr(off_level, 32'h0000_0004);
		send(0);
		chk("irq_level1", 32'h0000_0001, {31'h0, irq1});
		rd(off_vec1, 32'(vec_rxfull), 32'h0000_0003);
		rd(off_rxbuf, {16'h0000, w[15:0]}, 32'h0000_ffff);
		rd(off_flag, 32'h0000_0000, 32'h0000_0004);
		send(0);
		send(0);
		debug_mode <= 1;
		rd(off_flag, 32'h0000_0006, 32'h0000_0007);
		rd(off_vec0, 32'(vec_overrun), 32'h0000_0003);
		rd(off_flag, 32'h0000_0006, 32'h0000_0007);
		debug_mode <= 0;
		wr(off_flag, 32'h0000_0002);
		rd(off_flag, 32'h0000_0004, 32'h0000_0007);
		rd(off_rxbuf, {16'h0000, w[15:0]}, 32'h0000_ffff);
		rd(off_flag, 32'h0000_0000, 32'h0000_0004);
		flip <= 1;
		send(0);
		flip <= 0;
		chk("irq_level0", 32'h0000_0001, {31'h0, irq0});
		chk("irq", 32'h0000_0001, {31'h0, irq});
		rd(off_flag, 32'h0000_0001, 32'h0000_0001);
		rd(off_rxbuf, {16'h0000, ~w[15:0]}, 32'h0000_ffff);
		// inverted polarity on format one, picked before the word is sent
		wr(off_fmt1, 32'h0000_0104);
		apb(1, off_tx, 32'h0100_0000, 4'h8, 32'h0, 32'h0);
		repeat (250) @(posedge pclk);
		chk("sck_idle", 32'h0000_0001, {31'h0, sck});
		rd(off_flag, 32'h0000_0000, 32'h0000_0004);
		send(1);
		rd(off_rxbuf, {16'h0000, w[15:0]}, 32'h0000_ffff);
		stop_test();
	end
endmodule // tb
